/* File: hw/ppfm_cfg.svh */
// constants for the port pin function mux
`ifndef PPFM_CFG_SVH
`define PPFM_CFG_SVH
`define PPFM_PORT_W       8
`define PPFM_SYNC_RST     1'h0
`define PPFM_CFG_RST      8'h00
`define PPFM_DIR_RST      8'h00
`define PPFM_DATA_RST     8'h00
`define PPFM_BIT_ALE      3'h0
`define PPFM_BIT_RD       3'h1
`define PPFM_BIT_WRL      3'h2
`define PPFM_BIT_WRH      3'h3
`define PPFM_BIT_HREQ     3'h4
`define PPFM_BIT_HACK     3'h5
`define PPFM_BIT_RDY      3'h6
`define PPFM_BIT_CLK      3'h7
`define PPFM_BIT_UCLK     3'h0
`define PPFM_BIT_UTX      3'h1
`define PPFM_BIT_URX      3'h2
`define PPFM_BIT_ECLK     3'h3
`endif

/* File: hw/ppfm_pkg.sv */
// types for the port pin function mux
package ppfm_pkg;
   typedef enum logic {
      PPFM_SINGLE_CHIP,
      PPFM_EXT_BUS
   } ppfm_mode_type;
endpackage

/* File: hw/ppfm_pin_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module ppfm_pin_sync #(
   parameter int W = 8
) (
   input  wire logic         mclk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } ppfm_sync_type;
   ppfm_sync_type st_ff;
   ppfm_sync_type nxt_st;

   // level only moves once the second and third stages agree
   always_comb begin
      nxt_st    = st_ff;
      nxt_st.s1 = pin_i;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      for (int i = 0; i < W; i++) begin
         if (st_ff.s2[i] == st_ff.s3[i]) begin
            nxt_st.lvl[i] = st_ff.s3[i];
         end
      end
   end

   // registered state
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign level_o = st_ff.lvl;
endmodule
`default_nettype wire

/* File: hw/ppfm_port_mux.sv */
// pin function multiplexer for ports 0 to 4
`timescale 1ns/100ps
`default_nettype none
`include "ppfm_cfg.svh"
module ppfm_port_mux #(
   parameter int PW = `PPFM_PORT_W
) (
   input  wire logic          mclk_i,
   input  wire logic          rst_i,
   // mode and configuration
   input  wire logic          ext_bus_mode_i,
   input  wire logic          bus_16bit_i,
   input  wire logic          addr_out_sel_i,
   input  wire logic [PW-1:0] pullup_cfg_port0_i,
   input  wire logic [PW-1:0] pullup_cfg_port1_i,
   input  wire logic [PW-1:0] opendrain_cfg_port4_i,
   // port data and direction registers
   input  wire logic [PW-1:0] port0_data_i,
   input  wire logic [PW-1:0] port0_direction_bits_i,
   input  wire logic [PW-1:0] port1_data_i,
   input  wire logic [PW-1:0] port1_direction_bits_i,
   input  wire logic [PW-1:0] port2_data_i,
   input  wire logic [PW-1:0] port2_dir_i,
   input  wire logic [PW-1:0] port3_data_i,
   input  wire logic [PW-1:0] port3_dir_i,
   input  wire logic [PW-1:0] port4_data_i,
   input  wire logic [PW-1:0] port4_dir_i,
   // external bus controller side
   input  wire logic [PW-1:0] mux_bus_low_byte_out_i,
   input  wire logic [PW-1:0] mux_bus_high_byte_out_i,
   input  wire logic          bus_data_drive_i,
   input  wire logic [PW-1:0] upper_address_lines_i,
   input  wire logic          addr_latch_enable_i,
   input  wire logic          read_strobe_i,
   input  wire logic          write_strobe_low_byte_i,
   input  wire logic          write_strobe_high_byte_i,
   input  wire logic          bus_hold_acknowledge_i,
   input  wire logic          bus_clock_i,
   output logic               bus_hold_request_o,
   output logic               bus_ready_o,
   output logic [PW-1:0]      mux_bus_low_byte_in_o,
   output logic [PW-1:0]      mux_bus_high_byte_in_o,
   // serial peripherals
   input  wire logic          uart_clk_out_en_i,
   input  wire logic          uart_clk_out_i,
   input  wire logic          uart_tx_en_i,
   input  wire logic          uart_tx_i,
   input  wire logic          ext_serial_ch1_clk_en_i,
   input  wire logic          ext_serial_ch1_clk_out_i,
   output logic               uart_clk_in_o,
   output logic               uart_rx_o,
   output logic               ext_serial_ch1_clk_in_o,
   // pin input readback
   output logic [PW-1:0]      port0_read_o,
   output logic [PW-1:0]      port1_read_o,
   output logic [PW-1:0]      port2_read_o,
   output logic [PW-1:0]      port3_read_o,
   output logic [PW-1:0]      port4_read_o,
   // pads
   input  wire logic [PW-1:0] port0_pins_i,
   input  wire logic [PW-1:0] port1_pins_i,
   input  wire logic [PW-1:0] port2_pins_i,
   input  wire logic [PW-1:0] port3_pins_i,
   input  wire logic [PW-1:0] port4_pins_i,
   output logic [PW-1:0]      port0_pins_o,
   output logic [PW-1:0]      port0_pins_oe_o,
   output logic [PW-1:0]      port0_pullup_bits_o,
   output logic [PW-1:0]      port1_pins_o,
   output logic [PW-1:0]      port1_pins_oe_o,
   output logic [PW-1:0]      port1_pullup_bits_o,
   output logic [PW-1:0]      port2_pins_o,
   output logic [PW-1:0]      port2_pins_oe_o,
   output logic [PW-1:0]      port3_pins_o,
   output logic [PW-1:0]      port3_pins_oe_o,
   output logic [PW-1:0]      port4_pins_o,
   output logic [PW-1:0]      port4_pins_oe_o
);

   // ----------------------------------------------------------------
   // pin ownership summary
   // ----------------------------------------------------------------
   // port 0: gpio, or low address/data byte in bus mode
   // port 1: gpio, or high data byte on a 16-bit bus
   // port 2: gpio, or upper address lines when selected
   // port 3: gpio, or bus strobes, hold and ready in bus mode
   // port 4: gpio, serial clocks and transmit, open-drain shaping
   // a function that owns a pin sets its data, except hold request and ready, and its
   // enable, so the port registers lose that pin for the time
   // being; the pad level is still read back on every port
   // pull-ups follow the final enable, so a pin that the bus
   // drives never fights its own pull-up
   // timing: mode changes reach the pads in the same cycle as the
   // functions, both one cycle late through the output register, so
   // no strobe shows a stale gpio level; switch mode while the bus idles
   // limitation: port 4 bit 2 is never driven by a function here,
   // software keeps its gpio direction at input while the
   // uart receives
   // reset: every pad undriven, pull-ups off, ready high
   // inputs: pads pass a three-stage filter before any use
   // outputs: all registered, one cycle after the functions
   // ports 2 to 4 carry no pull-ups; port 4 alone has open-drain
   // bus enables on ports 0 and 1 are common to the whole byte
   // hold request reads low and ready reads high outside bus mode,
   // so the bus controller needs no mode check of its own
   // the serial units always see their pads, driven or not

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   // one packed struct holds every flop of the block except the synchroniser's own stages
   typedef struct packed {
      logic [PW-1:0] p0_o;
      logic [PW-1:0] p0_oe;
      logic [PW-1:0] p0_pu;
      logic [PW-1:0] p1_o;
      logic [PW-1:0] p1_oe;
      logic [PW-1:0] p1_pu;
      logic [PW-1:0] p2_o;
      logic [PW-1:0] p2_oe;
      logic [PW-1:0] p3_o;
      logic [PW-1:0] p3_oe;
      logic [PW-1:0] p4_o;
      logic [PW-1:0] p4_oe;
      logic [PW-1:0] rd0;
      logic [PW-1:0] rd1;
      logic [PW-1:0] rd2;
      logic [PW-1:0] rd3;
      logic [PW-1:0] rd4;
      logic [PW-1:0] lo_in;
      logic [PW-1:0] hi_in;
      logic          hreq;
      logic          rdy;
      logic          uclk;
      logic          urx;
      logic          eclk;
   } ppfm_state_type;

   // current and next state; the mode is a plain decode
   ppfm_state_type st_ff;
   ppfm_state_type nxt_st;
   ppfm_pkg::ppfm_mode_type mode;

   // filtered pad levels, one byte per port
   logic [PW-1:0] s0;
   logic [PW-1:0] s1;
   logic [PW-1:0] s2;
   logic [PW-1:0] s3;
   logic [PW-1:0] s4;

   // ----------------------------------------------------------------
   // pad input synchronisers
   // ----------------------------------------------------------------
   // pads are asynchronous to mclk, so every input is filtered
   // one wide instance keeps the five ports on identical latency
   // cost: a pad change reaches the outputs five cycles later
   // short glitches on a pad are lost, which is intended here
   ppfm_pin_sync #(.W(5*PW)) u_sync (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .pin_i   ({port4_pins_i, port3_pins_i, port2_pins_i, port1_pins_i, port0_pins_i}),
      .level_o ({s4, s3, s2, s1, s0})
   );

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   // one decode point keeps every pin group on the same mode
   assign mode = ext_bus_mode_i ? ppfm_pkg::PPFM_EXT_BUS : ppfm_pkg::PPFM_SINGLE_CHIP;

   // ----------------------------------------------------------------
   // pin function selection
   // ----------------------------------------------------------------
   // outputs are registered, so pads lag the internal functions by one
   // cycle; accepted to keep every output straight from a flip-flop
   always_comb begin
      nxt_st = st_ff;
      // ports 0 and 1 default to gpio
      // in bus mode the controller decides when data is driven
      nxt_st.p0_o  = port0_data_i;
      nxt_st.p0_oe = port0_direction_bits_i;
      nxt_st.p1_o  = port1_data_i;
      nxt_st.p1_oe = port1_direction_bits_i;
      if (mode == ppfm_pkg::PPFM_EXT_BUS) begin
         nxt_st.p0_o  = mux_bus_low_byte_out_i;
         nxt_st.p0_oe = {PW{bus_data_drive_i}};
         if (bus_16bit_i) begin
            nxt_st.p1_o  = mux_bus_high_byte_out_i;
            nxt_st.p1_oe = {PW{bus_data_drive_i}};
         end
      end

      // pull-ups only on pins that are not driving; the final
      // enable is used, so bus driving turns them off as well
      nxt_st.p0_pu = pullup_cfg_port0_i & ~nxt_st.p0_oe;
      nxt_st.p1_pu = pullup_cfg_port1_i & ~nxt_st.p1_oe;

      // port 2: upper address or gpio
      // the address setting takes all eight pins as outputs
      if (mode == ppfm_pkg::PPFM_EXT_BUS && addr_out_sel_i) begin
         nxt_st.p2_o  = upper_address_lines_i;
         nxt_st.p2_oe = '1;
      end else begin
         nxt_st.p2_o  = port2_data_i;
         nxt_st.p2_oe = port2_dir_i;
      end

      // port 3: bus strobes and handshakes
      // every output function takes its pin in bus mode, the
      // two inputs are released so the far side can drive them
      nxt_st.p3_o  = port3_data_i;
      nxt_st.p3_oe = port3_dir_i;
      if (mode == ppfm_pkg::PPFM_EXT_BUS) begin
         nxt_st.p3_o[`PPFM_BIT_ALE]   = addr_latch_enable_i;
         nxt_st.p3_o[`PPFM_BIT_RD]    = read_strobe_i;
         nxt_st.p3_o[`PPFM_BIT_WRL]   = write_strobe_low_byte_i;
         nxt_st.p3_o[`PPFM_BIT_WRH]   = write_strobe_high_byte_i;
         nxt_st.p3_o[`PPFM_BIT_HACK]  = bus_hold_acknowledge_i;
         nxt_st.p3_o[`PPFM_BIT_CLK]   = bus_clock_i;
         nxt_st.p3_oe[`PPFM_BIT_ALE]  = 1'b1;
         nxt_st.p3_oe[`PPFM_BIT_RD]   = 1'b1;
         nxt_st.p3_oe[`PPFM_BIT_WRL]  = 1'b1;
         nxt_st.p3_oe[`PPFM_BIT_WRH]  = 1'b1;
         nxt_st.p3_oe[`PPFM_BIT_HACK] = 1'b1;
         nxt_st.p3_oe[`PPFM_BIT_CLK]  = 1'b1;
         // request and ready are inputs in bus mode
         nxt_st.p3_oe[`PPFM_BIT_HREQ] = 1'b0;
         nxt_st.p3_oe[`PPFM_BIT_RDY]  = 1'b0;
      end
      // outside bus mode no hold is requested and the bus is ready
      // in bus mode both are taken from the filtered pad levels
      nxt_st.hreq = (mode == ppfm_pkg::PPFM_EXT_BUS) && s3[`PPFM_BIT_HREQ];
      nxt_st.rdy  = (mode != ppfm_pkg::PPFM_EXT_BUS) || s3[`PPFM_BIT_RDY];

      // port 4: serial functions, then open-drain shaping
      // serial enables override the direction bits; open-drain
      // shaping is applied last so it covers them as well
      nxt_st.p4_o  = port4_data_i;
      nxt_st.p4_oe = port4_dir_i;
      if (uart_clk_out_en_i) begin
         nxt_st.p4_o[`PPFM_BIT_UCLK]  = uart_clk_out_i;
         nxt_st.p4_oe[`PPFM_BIT_UCLK] = 1'b1;
      end
      if (uart_tx_en_i) begin
         nxt_st.p4_o[`PPFM_BIT_UTX]  = uart_tx_i;
         nxt_st.p4_oe[`PPFM_BIT_UTX] = 1'b1;
      end
      if (ext_serial_ch1_clk_en_i) begin
         nxt_st.p4_o[`PPFM_BIT_ECLK]  = ext_serial_ch1_clk_out_i;
         nxt_st.p4_oe[`PPFM_BIT_ECLK] = 1'b1;
      end
      // open-drain: a driven high becomes release; inputs stay untouched
      for (int i = 0; i < PW; i++) begin
         if (opendrain_cfg_port4_i[i] && nxt_st.p4_oe[i]) begin
            nxt_st.p4_oe[i] = ~nxt_st.p4_o[i];
            nxt_st.p4_o[i]  = 1'b0;
         end
      end
      // receive pin is only read; keeping it undriven is up to software
      nxt_st.urx  = s4[`PPFM_BIT_URX];
      nxt_st.uclk = s4[`PPFM_BIT_UCLK];
      nxt_st.eclk = s4[`PPFM_BIT_ECLK];

      // pin state stays readable whoever owns the pin
      nxt_st.rd0   = s0;
      nxt_st.rd1   = s1;
      nxt_st.rd2   = s2;
      nxt_st.rd3   = s3;
      nxt_st.rd4   = s4;
      // bus data inputs see the same filtered levels
      nxt_st.lo_in = s0;
      nxt_st.hi_in = s1;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // reset leaves all pads undriven with pull-ups off
   // ready resets high so a bus access is never stalled by reset
   // synchronous reset keeps every flop on the one clock edge
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         st_ff     <= '0;
         st_ff.rdy <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // all straight from flip-flops, so no pad sees a comb glitch
   // pad data, enables and pull-ups
   assign port0_pins_o            = st_ff.p0_o;
   assign port0_pins_oe_o         = st_ff.p0_oe;
   assign port0_pullup_bits_o     = st_ff.p0_pu;
   assign port1_pins_o            = st_ff.p1_o;
   assign port1_pins_oe_o         = st_ff.p1_oe;
   assign port1_pullup_bits_o     = st_ff.p1_pu;
   assign port2_pins_o            = st_ff.p2_o;
   assign port2_pins_oe_o         = st_ff.p2_oe;
   assign port3_pins_o            = st_ff.p3_o;
   assign port3_pins_oe_o         = st_ff.p3_oe;
   assign port4_pins_o            = st_ff.p4_o;
   assign port4_pins_oe_o         = st_ff.p4_oe;

   // filtered pin levels for readback
   assign port0_read_o            = st_ff.rd0;
   assign port1_read_o            = st_ff.rd1;
   assign port2_read_o            = st_ff.rd2;
   assign port3_read_o            = st_ff.rd3;
   assign port4_read_o            = st_ff.rd4;

   // filtered levels handed to the bus controller and serial units
   assign mux_bus_low_byte_in_o   = st_ff.lo_in;
   assign mux_bus_high_byte_in_o  = st_ff.hi_in;
   assign bus_hold_request_o      = st_ff.hreq;
   assign bus_ready_o             = st_ff.rdy;
   assign uart_clk_in_o           = st_ff.uclk;
   assign uart_rx_o               = st_ff.urx;
   assign ext_serial_ch1_clk_in_o = st_ff.eclk;
endmodule
`default_nettype wire

/* File: verif/ppfm_port_mux_monitor.sv */
// assertion checker for the port pin function mux
`timescale 1ns/100ps
`default_nettype none
module ppfm_port_mux_monitor #(
   parameter int PW = 8
) (
   input wire logic          mclk_i, rst_i, ext_bus_mode_i, bus_data_drive_i, addr_out_sel_i,
   input wire logic          read_strobe_i, bus_hold_request_o, bus_ready_o,
   input wire logic [PW-1:0] pullup_cfg_port0_i, port0_direction_bits_i, port0_pullup_bits_o,
   input wire logic [PW-1:0] port1_pullup_bits_o, port1_pins_oe_o, mux_bus_low_byte_out_i,
   input wire logic [PW-1:0] port0_pins_o, port0_pins_oe_o, upper_address_lines_i, port2_pins_o,
   input wire logic [PW-1:0] port2_pins_oe_o, port3_pins_o, port3_pins_oe_o, port3_pins_i,
   input wire logic [PW-1:0] opendrain_cfg_port4_i, port4_pins_o, port4_pins_oe_o
);
   // ----
   // one clock domain; $past(rst_i) skips the edge that leaves reset
   // ----
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // pad level held long enough to clear the synchroniser
   sequence s_hold_req;
      (ext_bus_mode_i && port3_pins_i[4]) [*6];
   endsequence
   sequence s_slow_dev;
      (ext_bus_mode_i && !port3_pins_i[6]) [*6];
   endsequence
   a_pullup_input: assert property (!$past(rst_i) && !$past(ext_bus_mode_i) |->
      port0_pullup_bits_o == ($past(pullup_cfg_port0_i) & ~$past(port0_direction_bits_i))) else $error("p0 pull-up");
   a_pullup_driven: assert property ((port1_pullup_bits_o & port1_pins_oe_o) == 8'h00)
      else $error("p1 pull-up on driven pin");
   a_bus_low_byte: assert property (!$past(rst_i) && $past(ext_bus_mode_i) && $past(bus_data_drive_i) |->
      port0_pins_oe_o == 8'hff && port0_pins_o == $past(mux_bus_low_byte_out_i)) else $error("p0 bus byte");
   a_upper_addr: assert property (!$past(rst_i) && $past(ext_bus_mode_i) && $past(addr_out_sel_i) |->
      port2_pins_oe_o == 8'hff && port2_pins_o == $past(upper_address_lines_i)) else $error("p2 address");
   a_strobe_pins: assert property (!$past(rst_i) && $past(ext_bus_mode_i) |->
      port3_pins_oe_o == 8'haf && port3_pins_o[1] == $past(read_strobe_i)) else $error("p3 strobes");
   a_hold_sync: assert property (s_hold_req |-> bus_hold_request_o)
      else $error("hold request lost");
   a_ready_slow: assert property (s_slow_dev |-> !bus_ready_o)
      else $error("ready not sampled");
   a_open_drain: assert property (!$past(rst_i) |->
      (port4_pins_o & port4_pins_oe_o & $past(opendrain_cfg_port4_i)) == 8'h00) else $error("p4 drives high");
endmodule
bind ppfm_port_mux ppfm_port_mux_monitor #(.PW(PW)) u_monitor (.*);
`default_nettype wire

/* File: verif/ppfm_bus_partner.sv */
// far side of the external bus: hold requester and slow ready
`timescale 1ns/100ps
`default_nettype none
module ppfm_bus_partner (
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   input  wire logic       hold_want_i,
   input  wire logic [2:0] wait_i,
   input  wire logic       rd_i,
   output logic      [1:0] drive_o
);
   // ----
   // wait states counted from the read strobe rising
   // ----
   logic [2:0] cnt_ff;
   logic       rd_ff;
   logic [2:0] nxt_cnt;
   always_comb nxt_cnt = (rd_i && !rd_ff) ? wait_i : ((cnt_ff != 3'h0) ? cnt_ff - 3'h1 : 3'h0);
   // levels change just after the edge, ready low while stalling
   always_ff @(posedge mclk_i) begin
      rd_ff   <= rst_i ? 1'b0 : rd_i;
      cnt_ff  <= rst_i ? 3'h0 : nxt_cnt;
      drive_o <= {nxt_cnt == 3'h0, hold_want_i};
   end
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the port pin function mux
`timescale 1ns/100ps
`default_nettype none
module testbench;
   typedef struct {int sel; logic [7:0] exp; logic [7:0] msk;} ppfm_note_type;
   logic mclk_i, rst_i, ext_bus_mode_i, bus_16bit_i, addr_out_sel_i, bus_data_drive_i, addr_latch_enable_i;
   logic read_strobe_i, write_strobe_low_byte_i, write_strobe_high_byte_i, bus_hold_acknowledge_i, bus_clock_i;
   logic uart_clk_out_en_i, uart_clk_out_i, uart_tx_en_i, uart_tx_i, ext_serial_ch1_clk_en_i, hold_want;
   logic ext_serial_ch1_clk_out_i, bus_hold_request_o, bus_ready_o, uart_clk_in_o, uart_rx_o;
   logic ext_serial_ch1_clk_in_o;
   logic [2:0] wait_n;
   logic [1:0] peer_drv;
   logic [7:0] pullup_cfg_port0_i, pullup_cfg_port1_i, opendrain_cfg_port4_i, port0_data_i, port1_data_i;
   logic [7:0] port0_direction_bits_i, port1_direction_bits_i, port2_data_i, port2_dir_i, port3_data_i;
   logic [7:0] port3_dir_i, port4_data_i, port4_dir_i, mux_bus_low_byte_out_i, mux_bus_high_byte_out_i;
   logic [7:0] upper_address_lines_i, mux_bus_low_byte_in_o, mux_bus_high_byte_in_o, e0, e1, e2, e3, e4;
   logic [7:0] port0_read_o, port1_read_o, port2_read_o, port3_read_o, port4_read_o, port0_pins_i;
   logic [7:0] port1_pins_i, port2_pins_i, port3_pins_i, port4_pins_i, port0_pins_o, port0_pins_oe_o;
   logic [7:0] port1_pins_o, port1_pins_oe_o, port2_pins_o, port2_pins_oe_o, port3_pins_o, port3_pins_oe_o;
   logic [7:0] port4_pins_o, port4_pins_oe_o, port0_pullup_bits_o, port1_pullup_bits_o;
   logic [20:0][7:0] obs;
   logic [191:0] r;
   logic [31:0] seed = 32'h0000_002f;
   int n_errors = 0;
   int tests_run = 0;
   ppfm_note_type notes[$];
   ppfm_note_type nt;
   // ----
   // pads: the driving party wins, else the far side's level
   // ----
   assign port0_pins_i = (port0_pins_o & port0_pins_oe_o) | (e0 & ~port0_pins_oe_o);
   assign port1_pins_i = (port1_pins_o & port1_pins_oe_o) | (e1 & ~port1_pins_oe_o);
   assign port2_pins_i = (port2_pins_o & port2_pins_oe_o) | (e2 & ~port2_pins_oe_o);
   assign port3_pins_i = (port3_pins_o & port3_pins_oe_o)
      | ({e3[7], peer_drv[1], e3[5], peer_drv[0], e3[3:0]} & ~port3_pins_oe_o);
   assign port4_pins_i = (port4_pins_o & port4_pins_oe_o) | (e4 & ~port4_pins_oe_o);
   // observed bytes, index 0 is port 0 pad out
   assign obs = {{5'h00, ext_serial_ch1_clk_in_o, uart_rx_o, uart_clk_in_o}, mux_bus_high_byte_in_o,
      mux_bus_low_byte_in_o, {6'h00, bus_ready_o, bus_hold_request_o}, port1_pullup_bits_o, port0_pullup_bits_o,
      port4_read_o, port4_pins_oe_o, port4_pins_o, port3_read_o, port3_pins_oe_o, port3_pins_o, port2_read_o,
      port2_pins_oe_o, port2_pins_o, port1_read_o, port1_pins_oe_o, port1_pins_o, port0_read_o, port0_pins_oe_o,
      port0_pins_o};
   ppfm_port_mux #(.PW(8)) uut (.*);
   ppfm_bus_partner peer (.mclk_i(mclk_i), .rst_i(rst_i), .hold_want_i(hold_want), .wait_i(wait_n),
      .rd_i(port3_pins_i[1]), .drive_o(peer_drv));
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic note(input int sel, input logic [7:0] exp, input logic [7:0] msk);
      notes.push_back('{sel, exp & msk, msk});
   endtask
   task automatic check(input int sel, input logic [7:0] exp, input logic [7:0] seen);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected output byte %0d expected %h seen %h", sel, exp, seen);
      end
   endtask
   task automatic stop_test();
      if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // random mode, configuration, data and far-side levels
   task automatic shake();
      r = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      {ext_bus_mode_i, bus_16bit_i, addr_out_sel_i, bus_data_drive_i, addr_latch_enable_i, read_strobe_i,
       write_strobe_low_byte_i, write_strobe_high_byte_i, bus_hold_acknowledge_i, bus_clock_i, uart_clk_out_en_i,
       uart_clk_out_i, uart_tx_en_i, uart_tx_i, ext_serial_ch1_clk_en_i, ext_serial_ch1_clk_out_i, hold_want,
       wait_n, pullup_cfg_port0_i, pullup_cfg_port1_i, opendrain_cfg_port4_i, port0_data_i, port1_data_i,
       port0_direction_bits_i, port1_direction_bits_i, port2_data_i, port2_dir_i, port3_data_i, port3_dir_i,
       port4_data_i, port4_dir_i, mux_bus_low_byte_out_i, mux_bus_high_byte_out_i, upper_address_lines_i,
       e0, e1, e2, e3, e4} = r[187:0];
      port4_dir_i[2] = 1'b0;
   endtask
   // reset clears pads and pull-ups, ready high, hold low
   task automatic reset_check();
      rst_i = 1'b1;
      repeat (2) @(negedge mclk_i);
      for (int k = 0; k < 17; k++) note(k, 8'h00, 8'hff);
      note(17, 8'h02, 8'hff);
      @(negedge mclk_i);
      rst_i = 1'b0;
   endtask
   task automatic expect_all();
      logic [4:0][7:0] oe;
      logic [4:0][7:0] v;
      logic [4:0][7:0] w;
      oe = {port4_dir_i, port3_dir_i, port2_dir_i, port1_direction_bits_i, port0_direction_bits_i};
      v = {port4_data_i, port3_data_i, port2_data_i, port1_data_i, port0_data_i};
      if (ext_bus_mode_i) begin
         oe[0] = {8{bus_data_drive_i}};
         v[0] = mux_bus_low_byte_out_i;
         oe[1] = bus_16bit_i ? {8{bus_data_drive_i}} : oe[1];
         v[1] = bus_16bit_i ? mux_bus_high_byte_out_i : v[1];
         oe[2] = addr_out_sel_i ? 8'hff : oe[2];
         v[2] = addr_out_sel_i ? upper_address_lines_i : v[2];
         oe[3] = 8'haf;
         v[3] = {bus_clock_i, 1'b0, bus_hold_acknowledge_i, 1'b0, write_strobe_high_byte_i,
            write_strobe_low_byte_i, read_strobe_i, addr_latch_enable_i};
      end
      oe[4] = oe[4] | {4'h0, ext_serial_ch1_clk_en_i, 1'b0, uart_tx_en_i, uart_clk_out_en_i};
      v[4][0] = uart_clk_out_en_i ? uart_clk_out_i : v[4][0];
      v[4][1] = uart_tx_en_i ? uart_tx_i : v[4][1];
      v[4][3] = ext_serial_ch1_clk_en_i ? ext_serial_ch1_clk_out_i : v[4][3];
      oe[4] = oe[4] & ~(opendrain_cfg_port4_i & v[4]);
      v[4] = v[4] & ~opendrain_cfg_port4_i;
      w = (v & oe) | ({e4, e3[7], peer_drv[1], e3[5], peer_drv[0], e3[3:0], e2, e1, e0} & ~oe);
      for (int k = 0; k < 5; k++) begin
         note(3 * k, v[k], oe[k]);
         note(3 * k + 1, oe[k], 8'hff);
         note(3 * k + 2, w[k], 8'hff);
      end
      note(15, pullup_cfg_port0_i & ~oe[0], 8'hff);
      note(16, pullup_cfg_port1_i & ~oe[1], 8'hff);
      note(17, ext_bus_mode_i ? {6'h00, w[3][6], w[3][4]} : 8'h02, 8'hff);
      note(18, w[0], 8'hff);
      note(19, w[1], 8'hff);
      note(20, {5'h00, w[4][3], w[4][2], w[4][0]}, 8'hff);
   endtask
   // every pending note is compared at the next rising edge, once the outputs have settled
   always @(posedge mclk_i) begin
      while (notes.size() > 0) begin
         nt = notes.pop_front();
         check(nt.sel, nt.exp, obs[nt.sel] & nt.msk);
      end
   end
   initial begin
      rst_i = 1'b1;
      shake();
      reset_check();
      for (int i = 0; i < 80; i++) begin
         @(negedge mclk_i);
         shake();
         repeat (15) @(negedge mclk_i);
         expect_all();
         if (i == 40) reset_check();
      end
      @(negedge mclk_i);
      stop_test();
   end
endmodule
`default_nettype wire
